// [dv/tb.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module tb
	import cbe_pkg::*;
;
	typedef struct {
		logic [7:0] idx;
		logic [7:0] wd;
		logic [7:0] rd;
	} cbe_row_t;

	logic                  aclk;
	logic                  aresetn;
	logic [11:0]           awaddr;
	logic                  awvalid;
	logic                  awready;
	logic [31:0]           wdata;
	logic [3:0]            wstrb;
	logic                  wvalid;
	logic                  wready;
	logic [1:0]            bresp;
	logic                  bvalid;
	logic                  bready;
	logic [11:0]           araddr;
	logic                  arvalid;
	logic                  arready;
	logic [31:0]           rdata;
	logic [1:0]            rresp;
	logic                  rvalid;
	logic                  rready;
	logic                  fs_en;
	logic                  en1;
	logic                  en2;
	logic                  en3;
	logic [CBE_EDGE_W-1:0] lo1;
	logic [CBE_EDGE_W-1:0] hi1;
	logic [CBE_EDGE_W-1:0] lo2;
	logic [CBE_EDGE_W-1:0] hi2;
	logic [CBE_EDGE_W-1:0] lo3;
	logic [CBE_EDGE_W-1:0] hi3;
	int                    fail_count;
	int                    n_checks;

	// Reserved bits are written as ones in rows a9, b1, b3 and b5 so the readback proves they are dropped.
	cbe_row_t rows [13] = '{
		'{8'ha9, 8'hff, 8'h0b}, '{8'hb0, 8'h34, 8'h34}, '{8'hb1, 8'hff, 8'h1f},
		'{8'hb2, 8'hcd, 8'hcd}, '{8'hb3, 8'hff, 8'h3f}, '{8'hb4, 8'h01, 8'h01},
		'{8'hb5, 8'he0, 8'h00}, '{8'hb6, 8'h10, 8'h10}, '{8'hb7, 8'h2a, 8'h2a},
		'{8'hb8, 8'h55, 8'h55}, '{8'hb9, 8'h03, 8'h03}, '{8'hba, 8'h66, 8'h66},
		'{8'hbb, 8'h1f, 8'h1f}
	};

	cbe_regs u_dut (
		.aclk                    (aclk),
		.aresetn                 (aresetn),
		.s_axi_awaddr            (awaddr),
		.s_axi_awprot            (3'h0),
		.s_axi_awvalid           (awvalid),
		.s_axi_awready           (awready),
		.s_axi_wdata             (wdata),
		.s_axi_wstrb             (wstrb),
		.s_axi_wvalid            (wvalid),
		.s_axi_wready            (wready),
		.s_axi_bresp             (bresp),
		.s_axi_bvalid            (bvalid),
		.s_axi_bready            (bready),
		.s_axi_araddr            (araddr),
		.s_axi_arprot            (3'h0),
		.s_axi_arvalid           (arvalid),
		.s_axi_arready           (arready),
		.s_axi_rdata             (rdata),
		.s_axi_rresp             (rresp),
		.s_axi_rvalid            (rvalid),
		.s_axi_rready            (rready),
		.fs_spec_enable          (fs_en),
		.first_window_enable     (en1),
		.first_window_low_edge   (lo1),
		.first_window_high_edge  (hi1),
		.second_window_enable    (en2),
		.second_window_low_edge  (lo2),
		.second_window_high_edge (hi2),
		.third_window_enable     (en3),
		.third_window_low_edge   (lo3),
		.third_window_high_edge  (hi3)
	);

	always #5 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: response %b expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_win(input int w, input logic e, input logic [12:0] lo, input logic [12:0] hi);
		logic [26:0] got;
		got = (w == 1) ? {en1, lo1, hi1} : (w == 2) ? {en2, lo2, hi2} : {en3, lo3, hi3};
		chk_data({5'h00, got}, {5'h00, e, lo, hi}, "window outputs");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Each channel is released at the edge where it is taken; a wait has no timeout of its own, only the watchdog.
	task automatic wr_chk(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h000000, d};
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				done = 1;
				chk_resp(bresp, er);
			end
		end
		chk_data(n, 32'd2, "write answer cycles");
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				done = 1;
				chk_resp(rresp, er);
				chk_data(rdata, ed, "read data");
			end
		end
		chk_data(n, 32'd2, "read answer cycles");
	endtask

	function automatic logic [11:0] adr(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		chk_data({22'h0, bresp, rresp, awready, wready, arready, bvalid, rvalid, fs_en}, 32'h0,
			"outputs in reset");
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_data({31'h0, fs_en}, 32'h0, "fs enable");
		for (int w = 1; w <= 3; w++) chk_win(w, 1'b0, 13'h0000, 13'h0000);
		foreach (rows[i]) rd_chk(adr(rows[i].idx), 32'h0, CBE_RESP_OKAY);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100us;
		fail_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		close_out();
	end

	initial begin
		aclk = 1'b0;
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} <= '0;
		{araddr, arvalid, rready} <= '0;
		fail_count = 0;
		n_checks = 0;
		do_reset();
		foreach (rows[i]) begin
			wr_chk(adr(rows[i].idx), rows[i].wd, 4'h1, CBE_RESP_OKAY);
			rd_chk(adr(rows[i].idx), {24'h0, rows[i].rd}, CBE_RESP_OKAY);
		end
		chk_data({31'h0, fs_en}, 32'h1, "fs enable");
		// The sample-rate value register lives outside this block and must not disturb it.
		wr_chk(adr(8'ha5), 8'h7d, 4'h1, CBE_RESP_SLVERR);
		rd_chk(adr(8'ha9), 32'h0b, CBE_RESP_OKAY);
		chk_data({31'h0, fs_en}, 32'h1, "fs enable");
		chk_win(1, 1'b1, 13'h1f34, 13'h1fcd);
		chk_win(2, 1'b1, 13'h0001, 13'h0a10);
		chk_win(3, 1'b0, 13'h0000, 13'h0000);
		// A write with its byte lane off must leave the register alone.
		wr_chk(adr(8'hb0), 8'h00, 4'h0, CBE_RESP_OKAY);
		rd_chk(adr(8'hb0), 32'h34, CBE_RESP_OKAY);
		wr_chk(adr(8'haa), 8'hff, 4'h1, CBE_RESP_SLVERR);
		rd_chk(adr(8'haa), 32'h0, CBE_RESP_SLVERR);
		wr_chk(12'h800 | adr(8'hb0), 8'h77, 4'h1, CBE_RESP_SLVERR);
		rd_chk(adr(8'hb0), 32'h34, CBE_RESP_OKAY);
		wr_chk(adr(8'hbb), 8'h3f, 4'h1, CBE_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk_win(3, 1'b1, 13'h0355, 13'h1f66);
		wr_chk(adr(8'hba), 8'hff, 4'h1, CBE_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk_win(3, 1'b1, 13'h0355, 13'h1fff);
		// Only the low byte changes, so the half-written edge shows at once.
		wr_chk(adr(8'hb2), 8'h00, 4'h1, CBE_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk_win(1, 1'b1, 13'h1f34, 13'h1f00);
		wr_chk(adr(8'hb3), 8'h1f, 4'h1, CBE_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk_win(1, 1'b0, 13'h0000, 13'h0000);
		rd_chk(adr(8'hb1), 32'h1f, CBE_RESP_OKAY);
		wr_chk(adr(8'ha9), 8'h03, 4'h1, CBE_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk_data({31'h0, fs_en}, 32'h0, "fs enable");
		rd_chk(adr(8'ha9), 32'h03, CBE_RESP_OKAY);
		do_reset();
		close_out();
	end
endmodule

// [hw/cbe_regs.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Bit 3 of fs_spec_control enables the user sample-rate setting and resets to 0.
// - First window low edge is {band1_low_edge_msb[4:0], band1_low_edge_lsb}, 13 bits.
// - First window high edge is {band1_high_edge_msb_enable[4:0], band1_high_edge_lsb}.
// - Second window low edge is {band2_low_edge_msb[4:0], band2_low_edge_lsb}, 13 bits.
// - Second window high edge is {band2_high_edge_msb_enable[4:0], band2_high_edge_lsb}.
// - Third window low edge is {band3_low_edge_msb[4:0], band3_low_edge_lsb}, 13 bits.
// - Third window high edge is {band3_high_edge_msb_enable[4:0], band3_high_edge_lsb}.
// - Each edge count weighs 1 MHz, so the largest edge is 8191 MHz.
// - Bit 5 of each upper-edge MSB register enables its window, else the edges are ignored.
module cbe_regs
	import cbe_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
	input  wire logic [2:0]              s_axi_awprot,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [CBE_DATA_W-1:0]   s_axi_wdata,
	input  wire logic [CBE_STRB_W-1:0]   s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [ADDR_W-1:0]       s_axi_araddr,
	input  wire logic [2:0]              s_axi_arprot,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [CBE_DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	output logic                         fs_spec_enable,
	output logic                         first_window_enable,
	output logic [CBE_EDGE_W-1:0]        first_window_low_edge,
	output logic [CBE_EDGE_W-1:0]        first_window_high_edge,
	output logic                         second_window_enable,
	output logic [CBE_EDGE_W-1:0]        second_window_low_edge,
	output logic [CBE_EDGE_W-1:0]        second_window_high_edge,
	output logic                         third_window_enable,
	output logic [CBE_EDGE_W-1:0]        third_window_low_edge,
	output logic [CBE_EDGE_W-1:0]        third_window_high_edge
);

	localparam int HI_W = ADDR_W - CBE_IDX_LSB - CBE_IDX_W;

	////////////////////////////////////////////////////////////////////////////////
	// Write channel state.

	cbe_wr_state_t         wr_q;
	cbe_wr_state_t         wr_d;
	logic                  awready_q;
	logic                  wready_q;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	logic [ADDR_W-1:0]     awaddr_q;
	logic [CBE_REG_W-1:0]  wbyte_q;
	logic                  wstrb0_q;

	logic                  aw_hs;
	logic                  w_hs;
	logic                  b_hs;
	logic                  wr_commit;
	logic [ADDR_W-1:0]     wr_addr;
	logic [CBE_IDX_W-1:0]  wr_idx;
	logic                  wr_idx_ok;
	logic [CBE_REG_W-1:0]  wr_byte;
	logic                  wr_strb0;
	logic                  wr_fs_bit;
	logic [CBE_NREG-1:0]   hit_w;
	logic                  wr_hit_any;

	assign aw_hs = s_axi_awvalid && awready_q;
	assign w_hs  = s_axi_wvalid && wready_q;
	assign b_hs  = bvalid_q && s_axi_bready;

	// Address and data may arrive in either order; use whichever copy is current.
	assign wr_addr   = aw_hs ? s_axi_awaddr : awaddr_q;
	assign wr_byte   = w_hs ? s_axi_wdata[CBE_REG_W-1:0] : wbyte_q;
	assign wr_strb0  = w_hs ? s_axi_wstrb[0] : wstrb0_q;
	assign wr_idx    = wr_addr[CBE_IDX_LSB +: CBE_IDX_W];
	assign wr_idx_ok = (wr_addr[ADDR_W-1 -: HI_W] == '0);
	assign wr_commit = (wr_d == CBE_WR_RESP) && (wr_q != CBE_WR_RESP);
	assign wr_hit_any = |hit_w;
	assign wr_fs_bit = wr_byte[CBE_FS_ENABLE_BIT];

	always_comb begin
		case (wr_q)
			CBE_WR_IDLE: begin
				if (aw_hs && w_hs) begin
					wr_d = CBE_WR_RESP;
				end else if (aw_hs) begin
					wr_d = CBE_WR_ADDR;
				end else if (w_hs) begin
					wr_d = CBE_WR_DATA;
				end else begin
					wr_d = CBE_WR_IDLE;
				end
			end
			CBE_WR_ADDR: begin
				wr_d = w_hs ? CBE_WR_RESP : CBE_WR_ADDR;
			end
			CBE_WR_DATA: begin
				wr_d = aw_hs ? CBE_WR_RESP : CBE_WR_DATA;
			end
			CBE_WR_RESP: begin
				wr_d = b_hs ? CBE_WR_IDLE : CBE_WR_RESP;
			end
			default: begin
				wr_d = CBE_WR_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_q      <= CBE_WR_IDLE;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= CBE_RESP_OKAY;
		end else begin
			wr_q      <= wr_d;
			awready_q <= (wr_d == CBE_WR_IDLE) || (wr_d == CBE_WR_DATA);
			wready_q  <= (wr_d == CBE_WR_IDLE) || (wr_d == CBE_WR_ADDR);
			bvalid_q  <= (wr_d == CBE_WR_RESP);
			if (wr_commit) begin
				bresp_q <= wr_hit_any ? CBE_RESP_OKAY : CBE_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_q <= '0;
			wbyte_q  <= '0;
			wstrb0_q <= 1'b0;
		end else begin
			if (aw_hs) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				wbyte_q  <= s_axi_wdata[CBE_REG_W-1:0];
				wstrb0_q <= s_axi_wstrb[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel state.

	cbe_rd_state_t         rd_q;
	cbe_rd_state_t         rd_d;
	logic                  arready_q;
	logic                  rvalid_q;
	logic [1:0]            rresp_q;
	logic [CBE_REG_W-1:0]  rbyte_q;
	logic                  ar_hs;
	logic                  r_hs;
	logic [CBE_IDX_W-1:0]  rd_idx;
	logic                  rd_idx_ok;
	logic [CBE_NREG-1:0]   hit_r;
	logic [CBE_REG_W-1:0]  rd_terms [CBE_NREG];
	logic [CBE_REG_W-1:0]  rd_byte;

	assign ar_hs     = s_axi_arvalid && arready_q;
	assign r_hs      = rvalid_q && s_axi_rready;
	assign rd_idx    = s_axi_araddr[CBE_IDX_LSB +: CBE_IDX_W];
	assign rd_idx_ok = (s_axi_araddr[ADDR_W-1 -: HI_W] == '0);

	always_comb begin
		case (rd_q)
			CBE_RD_IDLE: begin
				rd_d = ar_hs ? CBE_RD_DATA : CBE_RD_IDLE;
			end
			CBE_RD_DATA: begin
				rd_d = r_hs ? CBE_RD_IDLE : CBE_RD_DATA;
			end
			default: begin
				rd_d = CBE_RD_IDLE;
			end
		endcase
	end

	always_comb begin
		rd_byte = '0;
		for (int i = 0; i < CBE_NREG; i++) begin
			rd_byte = rd_byte | rd_terms[i];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_q      <= CBE_RD_IDLE;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= CBE_RESP_OKAY;
			rbyte_q   <= '0;
		end else begin
			rd_q      <= rd_d;
			arready_q <= (rd_d == CBE_RD_IDLE);
			rvalid_q  <= (rd_d == CBE_RD_DATA);
			if (ar_hs) begin
				rbyte_q <= rd_byte;
				rresp_q <= (|hit_r) ? CBE_RESP_OKAY : CBE_RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register storage; reserved bits are never stored and so read as zero.

	logic [CBE_REG_W-1:0] reg_q [CBE_NREG];

	for (genvar gi = 0; gi < CBE_NREG; gi++) begin : g_reg
		assign hit_w[gi]    = wr_idx_ok && (wr_idx == CBE_REG_IDX[gi]);
		assign hit_r[gi]    = rd_idx_ok && (rd_idx == CBE_REG_IDX[gi]);
		assign rd_terms[gi] = hit_r[gi] ? reg_q[gi] : '0;

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				reg_q[gi] <= CBE_RST_VAL;
			end else if (wr_commit && hit_w[gi] && wr_strb0) begin
				reg_q[gi] <= wr_byte & CBE_REG_MASK[gi];
			end
		end
	end

	assign fs_spec_enable = reg_q[CBE_POS_FS][CBE_FS_ENABLE_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Band windows.

	cbe_win_if win_if [CBE_NWIN] ();

	logic [CBE_EDGE_W-1:0] raw_low  [CBE_NWIN];
	logic [CBE_EDGE_W-1:0] raw_high [CBE_NWIN];
	logic [CBE_NWIN-1:0]   raw_en;

	for (genvar gw = 0; gw < CBE_NWIN; gw++) begin : g_win
		localparam int B = CBE_POS_WIN_BASE + gw * CBE_POS_PER_WIN;

		assign win_if[gw].low_lsb  = reg_q[B + CBE_OFS_LOW_LSB];
		assign win_if[gw].low_msb  = reg_q[B + CBE_OFS_LOW_MSB];
		assign win_if[gw].high_lsb = reg_q[B + CBE_OFS_HIGH_LSB];
		assign win_if[gw].high_msb = reg_q[B + CBE_OFS_HIGH_MSB];

		assign raw_low[gw]  = {reg_q[B + CBE_OFS_LOW_MSB][CBE_MSB_W-1:0],
			reg_q[B + CBE_OFS_LOW_LSB]};
		assign raw_high[gw] = {reg_q[B + CBE_OFS_HIGH_MSB][CBE_MSB_W-1:0],
			reg_q[B + CBE_OFS_HIGH_LSB]};
		assign raw_en[gw]   = reg_q[B + CBE_OFS_HIGH_MSB][CBE_WIN_ENABLE_BIT];

		cbe_window u_window (
			.aclk    (aclk),
			.aresetn (aresetn),
			.cfg     (win_if[gw])
		);
	end

	assign first_window_enable     = win_if[0].enable;
	assign first_window_low_edge   = win_if[0].low_edge;
	assign first_window_high_edge  = win_if[0].high_edge;
	assign second_window_enable    = win_if[1].enable;
	assign second_window_low_edge  = win_if[1].low_edge;
	assign second_window_high_edge = win_if[1].high_edge;
	assign third_window_enable     = win_if[2].enable;
	assign third_window_low_edge   = win_if[2].low_edge;
	assign third_window_high_edge  = win_if[2].high_edge;

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = {{(CBE_DATA_W-CBE_REG_W){1'b0}}, rbyte_q};

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	fs_enable_write_a: assert property (
		(wr_commit && hit_w[CBE_POS_FS] && wr_strb0) |=> (fs_spec_enable == $past(wr_fs_bit))
	) else $error("fs enable did not follow the written bit");

	win1_low_edge_a: assert property (
		##1 first_window_low_edge == ($past(raw_en[0]) ? $past(raw_low[0]) : '0)
	) else $error("first window low edge wrong");

	win1_high_edge_a: assert property (
		##1 first_window_high_edge == ($past(raw_en[0]) ? $past(raw_high[0]) : '0)
	) else $error("first window high edge wrong");

	win2_low_edge_a: assert property (
		##1 second_window_low_edge == ($past(raw_en[1]) ? $past(raw_low[1]) : '0)
	) else $error("second window low edge wrong");

	win2_high_edge_a: assert property (
		##1 second_window_high_edge == ($past(raw_en[1]) ? $past(raw_high[1]) : '0)
	) else $error("second window high edge wrong");

	win3_low_edge_a: assert property (
		##1 third_window_low_edge == ($past(raw_en[2]) ? $past(raw_low[2]) : '0)
	) else $error("third window low edge wrong");

	win3_high_edge_a: assert property (
		##1 third_window_high_edge == ($past(raw_en[2]) ? $past(raw_high[2]) : '0)
	) else $error("third window high edge wrong");

	edge_full_scale_a: assert property (
		(raw_en[2] && raw_high[2] == CBE_EDGE_MAX) |=> third_window_high_edge == CBE_EDGE_MAX
	) else $error("full scale edge not reached");

	win_disabled_a: assert property (
		!raw_en[1] |=> (!second_window_enable && second_window_low_edge == '0
			&& second_window_high_edge == '0)
	) else $error("disabled window shows edges");

	read_back_a: assert property (
		(ar_hs && hit_r != '0) |=> (s_axi_rvalid && s_axi_rresp == CBE_RESP_OKAY
			&& s_axi_rdata[CBE_REG_W-1:0] == $past(rd_byte))
	) else $error("read back value or timing wrong");

	write_resp_a: assert property (
		(aw_hs && w_hs) |=> (s_axi_bvalid && !s_axi_awready && !s_axi_wready)
	) else $error("write response missing");

	cover_fs_write_c: cover property (wr_commit && hit_w[CBE_POS_FS]);
	cover_bad_write_c: cover property (s_axi_bvalid && s_axi_bresp == CBE_RESP_SLVERR);
	cover_win_on_c: cover property (first_window_enable && first_window_high_edge != '0);
	cover_bad_read_c: cover property (s_axi_rvalid && s_axi_rresp == CBE_RESP_SLVERR);

endmodule

// [hw/cbe_window.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Assembles one band window from its four bytes and presents it registered.
module cbe_window
	import cbe_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	cbe_win_if.win    cfg
);

	logic [CBE_EDGE_W-1:0] low_raw;
	logic [CBE_EDGE_W-1:0] high_raw;
	logic                  enable_raw;
	logic [CBE_EDGE_W-1:0] low_edge_q;
	logic [CBE_EDGE_W-1:0] high_edge_q;
	logic                  enable_q;

	// Low byte from the LSB register, upper five bits from the MSB register.
	assign low_raw    = {cfg.low_msb[CBE_MSB_W-1:0], cfg.low_lsb};
	assign high_raw   = {cfg.high_msb[CBE_MSB_W-1:0], cfg.high_lsb};
	assign enable_raw = cfg.high_msb[CBE_WIN_ENABLE_BIT];

	// A disabled window shows zero edges so the correction loop never sees stale limits.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_edge_q  <= '0;
			high_edge_q <= '0;
			enable_q    <= 1'b0;
		end else begin
			low_edge_q  <= enable_raw ? low_raw : '0;
			high_edge_q <= enable_raw ? high_raw : '0;
			enable_q    <= enable_raw;
		end
	end

	assign cfg.low_edge  = low_edge_q;
	assign cfg.high_edge = high_edge_q;
	assign cfg.enable    = enable_q;

endmodule

// [include/cbe_pkg.sv]
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types for the channel band edge configuration block.
package cbe_pkg;

	localparam int CBE_NREG     = 13;
	localparam int CBE_NWIN     = 3;
	localparam int CBE_DATA_W   = 32;
	localparam int CBE_REG_W    = 8;
	localparam int CBE_IDX_W    = 8;
	localparam int CBE_IDX_LSB  = 2;
	localparam int CBE_EDGE_W   = 13;
	localparam int CBE_MSB_W    = 5;
	localparam int CBE_STRB_W   = CBE_DATA_W / 8;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address of each register is four times its index.
	localparam logic [7:0] CBE_IDX_FS_SPEC_CONTROL            = 8'ha9;
	localparam logic [7:0] CBE_IDX_BAND1_LOW_EDGE_LSB         = 8'hb0;
	localparam logic [7:0] CBE_IDX_BAND1_LOW_EDGE_MSB         = 8'hb1;
	localparam logic [7:0] CBE_IDX_BAND1_HIGH_EDGE_LSB        = 8'hb2;
	localparam logic [7:0] CBE_IDX_BAND1_HIGH_EDGE_MSB_ENABLE = 8'hb3;
	localparam logic [7:0] CBE_IDX_BAND2_LOW_EDGE_LSB         = 8'hb4;
	localparam logic [7:0] CBE_IDX_BAND2_LOW_EDGE_MSB         = 8'hb5;
	localparam logic [7:0] CBE_IDX_BAND2_HIGH_EDGE_LSB        = 8'hb6;
	localparam logic [7:0] CBE_IDX_BAND2_HIGH_EDGE_MSB_ENABLE = 8'hb7;
	localparam logic [7:0] CBE_IDX_BAND3_LOW_EDGE_LSB         = 8'hb8;
	localparam logic [7:0] CBE_IDX_BAND3_LOW_EDGE_MSB         = 8'hb9;
	localparam logic [7:0] CBE_IDX_BAND3_HIGH_EDGE_LSB        = 8'hba;
	localparam logic [7:0] CBE_IDX_BAND3_HIGH_EDGE_MSB_ENABLE = 8'hbb;

	// Writable bits of each register kind; all other bits read as zero.
	localparam logic [7:0] CBE_MASK_FS       = 8'h0b;
	localparam logic [7:0] CBE_MASK_LSB      = 8'hff;
	localparam logic [7:0] CBE_MASK_LOW_MSB  = 8'h1f;
	localparam logic [7:0] CBE_MASK_HIGH_MSB = 8'h3f;
	localparam logic [7:0] CBE_RST_VAL       = 8'h00;

	localparam int CBE_FS_ENABLE_BIT  = 3;
	localparam int CBE_WIN_ENABLE_BIT = 5;

	// Slot of each register in the storage array.
	localparam int CBE_POS_FS       = 0;
	localparam int CBE_POS_WIN_BASE = 1;
	localparam int CBE_POS_PER_WIN  = 4;
	localparam int CBE_OFS_LOW_LSB  = 0;
	localparam int CBE_OFS_LOW_MSB  = 1;
	localparam int CBE_OFS_HIGH_LSB = 2;
	localparam int CBE_OFS_HIGH_MSB = 3;

	localparam logic [7:0] CBE_REG_IDX [CBE_NREG] = '{
		CBE_IDX_FS_SPEC_CONTROL,
		CBE_IDX_BAND1_LOW_EDGE_LSB, CBE_IDX_BAND1_LOW_EDGE_MSB,
		CBE_IDX_BAND1_HIGH_EDGE_LSB, CBE_IDX_BAND1_HIGH_EDGE_MSB_ENABLE,
		CBE_IDX_BAND2_LOW_EDGE_LSB, CBE_IDX_BAND2_LOW_EDGE_MSB,
		CBE_IDX_BAND2_HIGH_EDGE_LSB, CBE_IDX_BAND2_HIGH_EDGE_MSB_ENABLE,
		CBE_IDX_BAND3_LOW_EDGE_LSB, CBE_IDX_BAND3_LOW_EDGE_MSB,
		CBE_IDX_BAND3_HIGH_EDGE_LSB, CBE_IDX_BAND3_HIGH_EDGE_MSB_ENABLE
	};

	localparam logic [7:0] CBE_REG_MASK [CBE_NREG] = '{
		CBE_MASK_FS,
		CBE_MASK_LSB, CBE_MASK_LOW_MSB, CBE_MASK_LSB, CBE_MASK_HIGH_MSB,
		CBE_MASK_LSB, CBE_MASK_LOW_MSB, CBE_MASK_LSB, CBE_MASK_HIGH_MSB,
		CBE_MASK_LSB, CBE_MASK_LOW_MSB, CBE_MASK_LSB, CBE_MASK_HIGH_MSB
	};

	localparam logic [CBE_EDGE_W-1:0] CBE_EDGE_MAX = 13'h1fff;

	localparam logic [1:0] CBE_RESP_OKAY   = 2'b00;
	localparam logic [1:0] CBE_RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		CBE_WR_IDLE = 2'b00,
		CBE_WR_RESP = 2'b01,
		CBE_WR_ADDR = 2'b11,
		CBE_WR_DATA = 2'b10
	} cbe_wr_state_t;

	typedef enum logic {
		CBE_RD_IDLE = 1'b0,
		CBE_RD_DATA = 1'b1
	} cbe_rd_state_t;

endpackage

// [include/cbe_win_if.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Carries one band window's raw register bytes out and its decoded edges back.
interface cbe_win_if;
	import cbe_pkg::*;

	logic [CBE_REG_W-1:0]  low_lsb;
	logic [CBE_REG_W-1:0]  low_msb;
	logic [CBE_REG_W-1:0]  high_lsb;
	logic [CBE_REG_W-1:0]  high_msb;
	logic [CBE_EDGE_W-1:0] low_edge;
	logic [CBE_EDGE_W-1:0] high_edge;
	logic                  enable;

	modport cfg (output low_lsb, output low_msb, output high_lsb, output high_msb,
		input low_edge, input high_edge, input enable);
	modport win (input low_lsb, input low_msb, input high_lsb, input high_msb,
		output low_edge, output high_edge, output enable);
endinterface
